// ==== cst_charge_ctrl.sv ====
`timescale 1ns/10ps
module cst_charge_ctrl
    import cst_pkg::*;
#(
    parameter int TICK_DIV = CLK_PER_SEC,
    parameter int CAP_W    = 8
) (
    input  wire logic             clk_sys_i,
    input  wire logic             nrst_i,
    input  wire logic             charge_enable_n_i,
    input  wire logic             vin_valid_i,
    input  wire logic             vin_over_limit_i,
    input  wire logic             batt_below_prequal_i,
    input  wire logic             batt_at_regulation_i,
    input  wire logic             current_below_done_i,
    input  wire logic             batt_below_restart_i,
    input  wire logic [2:0]       thermistor_zone_i,
    input  wire logic             current_set_short_i,
    input  wire logic             done_threshold_short_i,
    input  wire logic [CAP_W-1:0] timer_cap_units_i,
    output logic                  charger_on_o,
    output logic                  current_half_o,
    output logic                  vreg_reduced_o,
    output logic                  soft_start_o,
    output logic                  timer_fault_o,
    output logic                  done_o,
    output logic                  suspended_o,
    output logic [2:0]            state_o
);
    // Timing capacitance arrives in units of 0.1 uF; zero means pin grounded
    typedef struct packed {
        cst_state_e  st;
        logic [TMR_W-1:0] pq_sec;
        logic [TMR_W-1:0] fc_sec;
        logic [TMR_W-1:0] to_sec;
        logic        charger_on;
        logic        current_half;
        logic        vreg_reduced;
        logic        soft_start;
        logic        timer_fault;
        logic        done;
        logic        suspended;
    } cst_ctrl_s;

    cst_ctrl_s r;
    cst_ctrl_s next_r;
    logic      tick;
    logic      cold_hot;
    logic      susp;
    logic      timers_off;
    logic      shorted;
    logic      enabled;
    logic      timer_run;
    // Charging decode of the state being entered
    logic      entering_chg;
    logic [TMR_W-1:0] pq_limit;
    logic [TMR_W-1:0] fc_limit;
    cst_zone_e zone;

    // One-second tick from the system clock; TICK_DIV shortens it for simulation
    cst_tick_gen #(
        .DIV (TICK_DIV)
    ) u_tick (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .tick_o    (tick)
    );

    function automatic logic [TMR_W-1:0] limit_sec(input logic [CAP_W-1:0] units,
                                                   input int min_per_unit);
        limit_sec = TMR_W'(units * min_per_unit * SEC_PER_MIN);
    endfunction

    // One decode of the charging states keeps drive, suspend and short checks aligned
    function automatic logic is_charging(input cst_state_e s);
        is_charging = (s == CST_PREQUAL) || (s == CST_FAST) || (s == CST_TOPOFF);
    endfunction

    // Capacitor-scaled timers only expire while the timing pin is not grounded
    function automatic logic timer_expired(input logic [TMR_W-1:0] count,
                                           input logic [TMR_W-1:0] limit,
                                           input logic             off);
        timer_expired = !off && (count >= limit);
    endfunction

    // Undefined zone codes neither suspend nor rescale
    assign zone       = cst_zone_e'(thermistor_zone_i);
    assign cold_hot   = (zone == CST_ZONE_COLD) || (zone == CST_ZONE_HOT);
    assign susp       = cold_hot || vin_over_limit_i;
    // Top-off is not capacitor scaled, so it keeps running with the pin grounded
    assign timers_off = (timer_cap_units_i == '0);
    assign pq_limit   = limit_sec(timer_cap_units_i, PREQUAL_MIN_PER_UNIT);
    assign fc_limit   = limit_sec(timer_cap_units_i, FAST_MIN_PER_UNIT);
    assign shorted    = current_set_short_i || done_threshold_short_i;
    assign enabled    = !charge_enable_n_i && vin_valid_i;
    // Frozen while suspended, so a resumed state picks up its held count
    assign timer_run  = tick && !susp;

    always_comb begin
        next_r            = r;
        next_r.soft_start = 1'b0;
        case (r.st)
            CST_DISABLED: begin
                // Timers restart from zero on every exit from disable or fault
                next_r.pq_sec = '0;
                next_r.fc_sec = '0;
                next_r.to_sec = '0;
                if (enabled) begin
                    next_r.soft_start = 1'b1;
                    next_r.st = batt_below_prequal_i ? CST_PREQUAL : CST_FAST;
                end
            end
            CST_PREQUAL: begin
                if (timer_run && !timers_off) begin
                    next_r.pq_sec = r.pq_sec + TMR_W'(1);
                end
                // Moves wait out a suspension so charging resumes where it stopped
                if (!susp && !batt_below_prequal_i) begin
                    next_r.st = CST_FAST;
                end
                if (timer_expired(r.pq_sec, pq_limit, timers_off)) begin
                    next_r.st = CST_FAULT;
                end
            end
            CST_FAST: begin
                // Constant-current and constant-voltage share one timer
                if (timer_run && !timers_off) begin
                    next_r.fc_sec = r.fc_sec + TMR_W'(1);
                end
                next_r.to_sec = '0;
                if (!susp && batt_at_regulation_i && current_below_done_i) begin
                    next_r.st = CST_TOPOFF;
                end
                if (timer_expired(r.fc_sec, fc_limit, timers_off)) begin
                    next_r.st = CST_FAULT;
                end
            end
            CST_TOPOFF: begin
                // Top-off is fixed, not scaled by the capacitor
                if (timer_run) begin
                    next_r.to_sec = r.to_sec + TMR_W'(1);
                end
                if (!susp && !current_below_done_i) begin
                    next_r.st = CST_FAST;
                end else if (r.to_sec >= TMR_W'(TOPOFF_TICKS)) begin
                    next_r.st = CST_DONE;
                end
            end
            CST_DONE: begin
                // Straight back to fast-charge; soft-start only follows a cold start
                if (batt_below_restart_i) begin
                    next_r.fc_sec = '0;
                    next_r.st = CST_FAST;
                end
            end
            CST_FAULT: begin
                // Latched; only the enable pin or power cycle releases it
                next_r.pq_sec = '0;
                next_r.fc_sec = '0;
                next_r.to_sec = '0;
                if (charge_enable_n_i) begin
                    next_r.st = CST_DISABLED;
                end
            end
            default: next_r.st = CST_DISABLED;
        endcase

        // Shorted setting pins latch a fault from any charging state
        if (is_charging(r.st) && shorted) begin
            next_r.st = CST_FAULT;
        end
        // Enable and supply outrank every move except a latched fault
        if (r.st != CST_FAULT && !enabled) begin
            next_r.st = CST_DISABLED;
        end

        // State outputs follow the state being entered, so they line up with state_o
        entering_chg        = is_charging(next_r.st);
        next_r.done         = (next_r.st == CST_DONE);
        next_r.timer_fault  = (next_r.st == CST_FAULT);
        next_r.suspended    = susp && entering_chg;
        next_r.charger_on   = entering_chg && !susp;
        next_r.current_half = (zone == CST_ZONE_COOL) ? ISCALE_HALF
                                                      : ISCALE_FULL;
        next_r.vreg_reduced = (zone == CST_ZONE_WARM) ? VREG_REDUCED
                                                      : VREG_NORMAL;
    end

    // Constants only in the reset branch keep the power-up state known
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            r <= '{st: CST_DISABLED, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign charger_on_o   = r.charger_on;
    assign current_half_o = r.current_half;
    assign vreg_reduced_o = r.vreg_reduced;
    assign soft_start_o   = r.soft_start;
    assign timer_fault_o  = r.timer_fault;
    assign done_o         = r.done;
    assign suspended_o    = r.suspended;
    assign state_o        = r.st;
endmodule

// ==== cst_charge_ctrl_asserts.sv ====
`timescale 1ns/10ps
module cst_charge_ctrl_asserts
    import cst_pkg::*;
(
    input wire logic       clk_sys_i,
    input wire logic       nrst_i,
    input wire logic       charge_enable_n_i,
    input wire logic       vin_valid_i,
    input wire logic       vin_over_limit_i,
    input wire logic [2:0] thermistor_zone_i,
    input wire logic       current_set_short_i,
    input wire logic       done_threshold_short_i,
    input wire logic       charger_on_o,
    input wire logic       current_half_o,
    input wire logic       vreg_reduced_o,
    input wire logic       timer_fault_o,
    input wire logic       done_o,
    input wire logic       suspended_o,
    input wire logic [2:0] state_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    // Shorts win over zone moves, so zone checks exclude them
    wire logic ok      = !charge_enable_n_i && vin_valid_i && !current_set_short_i
                         && !done_threshold_short_i;
    wire logic wz      = thermistor_zone_i inside {3'h1, 3'h2, 3'h3};
    wire logic chg_any = state_o inside {CST_PREQUAL, CST_FAST, CST_TOPOFF};
    // Top-off may end in done, so zone targets are watched outside it
    wire logic go      = ok && !vin_over_limit_i && state_o inside {CST_PREQUAL, CST_FAST};
    sequence s_held;
        !charger_on_o && suspended_o && $stable(state_o);
    endsequence
    sequence s_on;
        charger_on_o && !suspended_o;
    endsequence
    done_off_a: assert property (done_o |-> !charger_on_o && state_o == CST_DONE)
        else $error("done state with charger running");
    short_flt_a: assert property (chg_any && !charge_enable_n_i && vin_valid_i && wz
        && !vin_over_limit_i && (current_set_short_i || done_threshold_short_i)
        |=> timer_fault_o && !charger_on_o) else $error("pin short did not fault");
    flt_hold_a: assert property (timer_fault_o && !charge_enable_n_i |=> timer_fault_o)
        else $error("fault cleared while enabled");
    cold_hot_a: assert property (chg_any && ok && !wz |=> s_held)
        else $error("charger not held in cold or hot zone");
    charge_resume_a: assert property (suspended_o && go && wz |=> s_on)
        else $error("charger did not resume");
    over_volt_a: assert property (chg_any && ok && vin_over_limit_i |=> s_held)
        else $error("charger not held at over-voltage");
    cool_half_a: assert property (go && thermistor_zone_i == 3'h1 |=> s_on ##0 current_half_o)
        else $error("cool zone current not halved");
    warm_vreg_a: assert property (go && thermistor_zone_i == 3'h3 |=> s_on ##0 vreg_reduced_o)
        else $error("warm zone target not reduced");
    enable_off_a: assert property (charge_enable_n_i |=> !charger_on_o)
        else $error("charger on while disabled");
endmodule
bind cst_charge_ctrl cst_charge_ctrl_asserts i_cst_charge_ctrl_asserts (.*);

// ==== cst_charge_ctrl_tb.sv ====
`timescale 1ns/10ps
module cst_charge_ctrl_tb
    import cst_pkg::*;
;
    logic       clk_sys_i              = 1'h0;
    logic       nrst_i                 = 1'h0;
    logic       vin_valid_i            = 1'h1;
    logic       vin_over_limit_i       = 1'h0;
    logic       current_set_short_i    = 1'h0;
    logic       done_threshold_short_i = 1'h0;
    logic [7:0] timer_cap_units_i      = 8'h01;
    logic       charge_enable_n_i, batt_below_prequal_i, batt_at_regulation_i;
    logic       current_below_done_i, batt_below_restart_i, charger_on_o, current_half_o;
    logic       vreg_reduced_o, soft_start_o, timer_fault_o, done_o, suspended_o;
    logic [2:0] thermistor_zone_i, state_o;
    int         fails     = 0;
    int         tests_run = 0;
    cst_charge_ctrl #(.TICK_DIV(4), .CAP_W(8)) i_cst_charge_ctrl (.*);
    cst_partner i_cst_partner (.charge_enable_n_o(charge_enable_n_i), .zone_o(thermistor_zone_i),
        .below_prequal_o(batt_below_prequal_i), .at_reg_o(batt_at_regulation_i),
        .below_done_o(current_below_done_i), .below_restart_o(batt_below_restart_i));
    always #50 clk_sys_i = ~clk_sys_i;
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic t_start;
        i_cst_partner.put(1'h0, 3'h2, 3'h2);
        step(1);
        chk({charger_on_o, soft_start_o, state_o}, {2'h3, CST_FAST});
        i_cst_partner.put(1'h1, 3'h2, 3'h2);
        step(1);
        chk({charger_on_o, soft_start_o, state_o}, {2'h0, CST_DISABLED});
        vin_valid_i = 1'h0;
        i_cst_partner.put(1'h0, 3'h2, 3'h1);
        step(2);
        chk({charger_on_o, state_o}, {1'h0, CST_DISABLED});
        vin_valid_i = 1'h1;
        step(1);
        chk({charger_on_o, soft_start_o, state_o}, {2'h3, CST_PREQUAL});
        $display("start and disable done");
    endtask
    task automatic t_topoff;
        i_cst_partner.put(1'h0, 3'h2, 3'h3);
        step(3);
        i_cst_partner.put(1'h0, 3'h2, 3'h4);
        step(57);
        chk(state_o, CST_TOPOFF);
        step(16);
        chk({done_o, charger_on_o}, 2'h2);
        i_cst_partner.put(1'h0, 3'h2, 3'h5);
        step(1);
        chk({soft_start_o, state_o}, {1'h0, CST_FAST});
        $display("top-off and restart done");
    endtask
    task automatic t_zone;
        for (int z = 0; z < 6; z++) begin
            vin_over_limit_i = (z == 5);
            i_cst_partner.put(1'h0, (z == 5) ? 3'h2 : z[2:0], 3'h2);
            step(1);
            chk(charger_on_o, z inside {1, 2, 3});
            chk(suspended_o, !(z inside {1, 2, 3}));
            chk({current_half_o, vreg_reduced_o}, {z == 1, z == 3});
            chk(state_o, CST_FAST);
        end
        vin_over_limit_i = 1'h0;
        step(1);
        chk(charger_on_o, 1'h1);
        $display("zones done");
    endtask
    task automatic t_fault;
        for (int i = 0; i < 2; i++) begin
            {current_set_short_i, done_threshold_short_i} = i[0] ? 2'h1 : 2'h2;
            step(1);
            {current_set_short_i, done_threshold_short_i} = 2'h0;
            i_cst_partner.put(1'h0, 3'h4, 3'h5);
            step(4);
            chk({timer_fault_o, charger_on_o}, 2'h2);
            i_cst_partner.put(1'h1, 3'h2, 3'h2);
            step(1);
            chk(state_o, CST_DISABLED);
            i_cst_partner.put(1'h0, 3'h2, 3'h2);
            step(1);
            chk(state_o, CST_FAST);
        end
        $display("faults done");
    endtask
    task automatic t_timer(input logic [7:0] u, input logic [2:0] l, input int lim, input logic f);
        i_cst_partner.put(1'h1, 3'h2, l);
        timer_cap_units_i = u;
        step(2);
        i_cst_partner.put(1'h0, 3'h0, l);
        step(40);
        chk({suspended_o, state_o}, {1'h1, (l == 3'h1) ? CST_PREQUAL : CST_FAST});
        i_cst_partner.put(1'h0, 3'h2, l);
        step(lim * 4 - 8);
        chk(timer_fault_o, 1'h0);
        step(16);
        chk(timer_fault_o, f);
        $display("timer of %0d ticks done", lim);
    endtask
    initial begin
        step(12);
        nrst_i = 1'h1;
        step(1);
        t_start;
        t_topoff;
        t_zone;
        t_fault;
        t_timer(8'h01, 3'h1, PREQUAL_MIN_PER_UNIT * SEC_PER_MIN, 1'h1);
        t_timer(8'h01, 3'h2, FAST_MIN_PER_UNIT * SEC_PER_MIN, 1'h1);
        t_timer(8'h00, 3'h1, PREQUAL_MIN_PER_UNIT * SEC_PER_MIN, 1'h0);
        results;
    end
    // About 58k cycles of work; the limit leaves some slack
    initial begin
        #7000000;
        fails++;
        results;
    end
endmodule

// ==== cst_partner.sv ====
`timescale 1ns/10ps
module cst_partner (
    output logic       charge_enable_n_o,
    output logic [2:0] zone_o,
    output logic       below_prequal_o,
    output logic       at_reg_o,
    output logic       below_done_o,
    output logic       below_restart_o
);
    // Cell level: 1 low, 2 bulk, 3 at target, 4 tapered, 5 self-discharged
    logic [2:0] lvl = 3'h2;
    // Controller holds the charger off until told otherwise
    initial charge_enable_n_o = 1'h1;
    initial zone_o = 3'h2;
    assign below_prequal_o = lvl == 3'h1;
    assign at_reg_o        = lvl inside {3'h3, 3'h4};
    assign below_done_o    = lvl == 3'h4;
    assign below_restart_o = lvl == 3'h5;
    // A low to high toggle of en_n is the controller's only way out of a fault
    task automatic put(input logic en_n, input logic [2:0] z, input logic [2:0] l);
        charge_enable_n_o = en_n;
        zone_o            = z;
        lvl               = l;
    endtask
endmodule

// ==== cst_pkg.sv ====
package cst_pkg;

    // Timer figures, in their printed units
    localparam int PREQUAL_MIN_PER_UNIT = 30;   // per 0.1 uF of timing capacitance
    localparam int FAST_MIN_PER_UNIT    = 180;  // per 0.1 uF of timing capacitance
    localparam int TOPOFF_S             = 16;
    localparam int SEC_PER_MIN          = 60;

    // Top-off time as whole seconds of the one-second tick
    localparam int TOPOFF_TICKS = TOPOFF_S;

    // Clock and derived one-second tick
    localparam int CLK_HZ        = 10000000;
    localparam int CLK_PER_SEC   = CLK_HZ;

    localparam int TMR_W = 24;

    // Voltage target selects
    localparam logic VREG_NORMAL  = 1'b0;
    localparam logic VREG_REDUCED = 1'b1;   // 4.075 V target
    // Current scale selects
    localparam logic ISCALE_FULL  = 1'b0;   // 100 % of programmed
    localparam logic ISCALE_HALF  = 1'b1;   // 50 % of programmed

    // Thermistor zone code from the comparator bank
    typedef enum logic [2:0] {
        CST_ZONE_COLD,      // below cold_limit
        CST_ZONE_COOL,      // cold_limit .. cool_limit
        CST_ZONE_NORMAL,    // cool_limit .. warm_limit
        CST_ZONE_WARM,      // warm_limit .. hot_limit
        CST_ZONE_HOT        // above hot_limit
    } cst_zone_e;

    typedef enum logic [2:0] {
        CST_DISABLED,
        CST_PREQUAL,
        CST_FAST,
        CST_TOPOFF,
        CST_DONE,
        CST_FAULT
    } cst_state_e;

    // Tick divider state
    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } cst_tick_s;

endpackage

// ==== cst_tick_gen.sv ====
`timescale 1ns/10ps
module cst_tick_gen
    import cst_pkg::*;
#(
    parameter int DIV = CLK_PER_SEC
) (
    input  wire logic clk_sys_i,
    input  wire logic nrst_i,
    output logic      tick_o
);
    cst_tick_s r;
    cst_tick_s next_r;

    always_comb begin
        next_r      = r;
        next_r.tick = 1'b0;
        if (r.cnt >= 32'(DIV - 1)) begin
            next_r.cnt  = '0;
            next_r.tick = 1'b1;
        end else begin
            next_r.cnt = r.cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tick_o = r.tick;
endmodule
